// >>> hw/portb_mux_pkg.sv
package portb_mux_pkg;

    // ========================================================
    // pin positions and widths
    // ========================================================
    localparam int PIN_COUNT      = 8;
    localparam int RESET_PIN      = 7;
    localparam int INT_ZERO_PIN   = 6;
    localparam int OSC_TWO_PIN    = 5;
    localparam int OSC_ONE_PIN    = 4;
    localparam int SER_CLOCK_PIN  = 2;
    localparam int SER_DOUT_PIN   = 1;
    localparam int SER_DIN_PIN    = 0;

    // ========================================================
    // steering field layout in timer1_control_d
    // ========================================================
    // channel a letters u..x sit in bits 3..0, channel b in 7..4
    localparam int STEER_A_BASE   = 0;
    localparam int STEER_B_BASE   = 4;

    // ========================================================
    // source numbering seen by other units
    // ========================================================
    localparam int PIN_CHANGE_BASE = 8;
    localparam int ANALOG_CH_PIN7  = 10;
    localparam int ANALOG_CH_PIN6  = 9;
    localparam int ANALOG_CH_PIN5  = 8;

    // ========================================================
    // reset values and divider defaults
    // ========================================================
    localparam logic [7:0] BYTE_RESET  = 8'h00;
    localparam int         DIV_WIDTH   = 4;
    localparam logic [3:0] DIV_DEFAULT = 4'h0;

    typedef logic [PIN_COUNT-1:0] port_byte_t;

endpackage : portb_mux_pkg

// >>> hw/clock_output_divider.sv
`timescale 1ns/100ps

module clock_output_divider #(
    parameter int WIDTH = 4
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_in,
    input  wire logic [WIDTH-1:0] div_sel_in,
    output logic                  divided_clock_out
);

    // ========================================================
    // half-period counter
    // ========================================================
    // output toggles every div_sel_in+1 cycles, so the divided
    // clock period is 2*(div_sel_in+1) reference cycles
    logic [WIDTH-1:0] count_q;
    logic             wrap;

    assign wrap = (count_q >= div_sel_in);

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            count_q <= '0;
        end else if (wrap) begin
            count_q <= '0;
        end else begin
            count_q <= count_q + WIDTH'(1);
        end
    end

    // ========================================================
    // output toggle
    // ========================================================
    // only the block reset stops it, never the chip reset
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            divided_clock_out <= 1'b0;
        end else if (wrap) begin
            divided_clock_out <= ~divided_clock_out;
        end
    end

endmodule : clock_output_divider

// >>> hw/port_b_alt_function_mux.sv
`timescale 1ns/100ps

module port_b_alt_function_mux #(
    parameter int DIV_WIDTH = portb_mux_pkg::DIV_WIDTH
) (
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_in,
    // pad side
    input  wire portb_mux_pkg::port_byte_t pad_in,
    output portb_mux_pkg::port_byte_t      pad_out,
    output portb_mux_pkg::port_byte_t      pad_oe_out,
    output portb_mux_pkg::port_byte_t      pad_pullup_out,
    // port register side
    input  wire portb_mux_pkg::port_byte_t port_dir_in,
    input  wire portb_mux_pkg::port_byte_t port_latch_in,
    input  wire logic                      pullup_disable_in,
    output portb_mux_pkg::port_byte_t      dir_read_out,
    output portb_mux_pkg::port_byte_t      latch_read_out,
    output portb_mux_pkg::port_byte_t      input_read_out,
    // fuses and clock selection, 1 = programmed / selected
    input  wire logic                      reset_disable_fuse_in,
    input  wire logic                      debug_enable_fuse_in,
    input  wire logic                      lock_bits_programmed_in,
    input  wire logic                      clock_output_fuse_in,
    input  wire logic                      crystal_osc_sel_in,
    input  wire logic                      internal_rc_sel_in,
    input  wire logic [DIV_WIDTH-1:0]      clock_div_sel_in,
    // timer 1
    input  wire logic                      timer1_a_enable_in,
    input  wire logic                      timer1_b_enable_in,
    input  wire logic                      timer1_a_cmp_in,
    input  wire logic                      timer1_b_cmp_in,
    input  wire portb_mux_pkg::port_byte_t timer1_control_d_in,
    // universal serial unit
    input  wire logic                      serial_two_wire_in,
    input  wire logic                      serial_three_wire_in,
    input  wire logic                      serial_shiftout_in,
    input  wire logic                      serial_clock_hold_in,
    output logic                           serial_unit_clock_in_out,
    output logic                           serial_unit_data_in_out,
    // debug line
    input  wire logic                      debug_drive_low_in,
    output logic                           one_wire_debug_line_out,
    output logic                           debug_active_out,
    // reset, interrupts, analog, clocks
    output logic                           reset_request_out,
    output portb_mux_pkg::port_byte_t      pin_change_out,
    output logic                           external_interrupt_zero_out,
    output logic [2:0]                     analog_channel_out,
    output logic                           external_clock_in_out
);
    import portb_mux_pkg::*;

    // ========================================================
    // helpers
    // ========================================================
    // steering bit for pin n: letter index n/2, channel from n[0]
    function automatic logic timer_steer(input int pin,
                                         input port_byte_t ctl);
        int idx;
        idx = pin / 2;
        if ((pin % 2) == 1) begin
            timer_steer = ctl[STEER_B_BASE + idx];
        end else begin
            timer_steer = ctl[STEER_A_BASE + idx];
        end
    endfunction : timer_steer

    // ========================================================
    // fuse and clock claims
    // ========================================================
    logic reset_claim;
    logic debug_claim;
    logic pin7_claim;
    logic osc_two_claim;
    logic clk_out_claim;
    logic osc_one_claim;
    logic divided_clock;

    assign reset_claim   = ~reset_disable_fuse_in;
    assign debug_claim   = debug_enable_fuse_in
                         & ~lock_bits_programmed_in;
    assign pin7_claim    = reset_claim | debug_claim;
    assign osc_two_claim = crystal_osc_sel_in;
    // the crystal needs the pin, so it wins over the clock output
    assign clk_out_claim = clock_output_fuse_in & ~osc_two_claim;
    assign osc_one_claim = ~internal_rc_sel_in;

    // chip reset is not an input here: the divider stops only for
    // the block reset, so the clock keeps running on bit 5
    clock_output_divider #(
        .WIDTH             (DIV_WIDTH)
    ) u_clkdiv (
        .ref_clk_in        (ref_clk_in),
        .rst_in            (rst_in),
        .div_sel_in        (clock_div_sel_in),
        .divided_clock_out (divided_clock)
    );

    // ========================================================
    // timer 1 per-pin overrides
    // ========================================================
    port_byte_t timer_use;
    port_byte_t timer_val;

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_timer
        logic chan_en;
        logic chan_val;
        assign chan_en  = (i % 2 == 1) ? timer1_b_enable_in
                                       : timer1_a_enable_in;
        assign chan_val = (i % 2 == 1) ? timer1_b_cmp_in
                                       : timer1_a_cmp_in;
        // direction still comes from the port; software must set it
        assign timer_use[i] = chan_en
                            & timer_steer(i, timer1_control_d_in);
        assign timer_val[i] = chan_val;
    end

    // ========================================================
    // default port behaviour per pin
    // ========================================================
    port_byte_t base_out;
    port_byte_t base_oe;
    port_byte_t base_pu;

    for (genvar i = 0; i < PIN_COUNT; i++) begin : g_base
        assign base_out[i] = timer_use[i] ? timer_val[i]
                                          : port_latch_in[i];
        assign base_oe[i]  = port_dir_in[i];
        assign base_pu[i]  = port_latch_in[i] & ~port_dir_in[i]
                           & ~pullup_disable_in;
    end

    // ========================================================
    // serial overrides on bits 2..0
    // ========================================================
    // kept apart from the claims so no serial bit can undo a fuse
    port_byte_t ser_out;
    port_byte_t ser_oe;

    always_comb begin
        ser_out = base_out;
        ser_oe  = base_oe;
        // two-wire data is open drain: only ever pulls low
        if (serial_two_wire_in) begin
            ser_out[SER_DIN_PIN]   = 1'b0;
            ser_oe[SER_DIN_PIN]    = port_dir_in[SER_DIN_PIN]
                                   & ~serial_shiftout_in;
            ser_out[SER_CLOCK_PIN] = 1'b0;
            ser_oe[SER_CLOCK_PIN]  = port_dir_in[SER_CLOCK_PIN]
                                   & (serial_clock_hold_in
                                      | ~port_latch_in[SER_CLOCK_PIN]);
        end
        // three-wire data out replaces the latch when driven
        if (serial_three_wire_in && !serial_two_wire_in) begin
            ser_out[SER_DOUT_PIN] = serial_shiftout_in;
        end
    end

    // ========================================================
    // final pad drive, claims first
    // ========================================================
    port_byte_t pad_d;
    port_byte_t oe_d;
    port_byte_t pu_d;

    always_comb begin
        pad_d = ser_out;
        oe_d  = ser_oe;
        pu_d  = base_pu;

        // fuse and clock claims override everything below them
        if (osc_one_claim) begin
            pad_d[OSC_ONE_PIN] = 1'b0;
            oe_d[OSC_ONE_PIN]  = 1'b0;
            pu_d[OSC_ONE_PIN]  = 1'b0;
        end
        if (osc_two_claim) begin
            pad_d[OSC_TWO_PIN] = 1'b0;
            oe_d[OSC_TWO_PIN]  = 1'b0;
            pu_d[OSC_TWO_PIN]  = 1'b0;
        end else if (clk_out_claim) begin
            pad_d[OSC_TWO_PIN] = divided_clock;
            oe_d[OSC_TWO_PIN]  = 1'b1;
            pu_d[OSC_TWO_PIN]  = 1'b0;
        end
        if (debug_claim) begin
            pad_d[RESET_PIN] = 1'b0;
            oe_d[RESET_PIN]  = debug_drive_low_in;
            pu_d[RESET_PIN]  = 1'b1;
        end else if (reset_claim) begin
            pad_d[RESET_PIN] = 1'b0;
            oe_d[RESET_PIN]  = 1'b0;
            pu_d[RESET_PIN]  = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pad_out <= BYTE_RESET;
        end else begin
            pad_out <= pad_d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pad_oe_out <= BYTE_RESET;
        end else begin
            pad_oe_out <= oe_d;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            pad_pullup_out <= BYTE_RESET;
        end else begin
            pad_pullup_out <= pu_d;
        end
    end

    // ========================================================
    // input sampling
    // ========================================================
    port_byte_t sample_q;

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            sample_q <= BYTE_RESET;
        end else begin
            sample_q <= pad_in;
        end
    end

    // ========================================================
    // register read-back masking
    // ========================================================
    port_byte_t read_mask;

    always_comb begin
        read_mask              = BYTE_RESET;
        read_mask[RESET_PIN]   = pin7_claim;
        read_mask[OSC_ONE_PIN] = osc_one_claim;
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            dir_read_out <= BYTE_RESET;
        end else begin
            dir_read_out <= port_dir_in & ~read_mask;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            latch_read_out <= BYTE_RESET;
        end else begin
            latch_read_out <= port_latch_in & ~read_mask;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            input_read_out <= BYTE_RESET;
        end else begin
            input_read_out <= pad_in & ~read_mask;
        end
    end

    // ========================================================
    // reset and debug line
    // ========================================================
    // reset pin is active low; the request is one cycle behind
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            reset_request_out <= 1'b0;
        end else begin
            reset_request_out <= reset_claim & ~debug_claim
                               & ~pad_in[RESET_PIN];
        end
    end

    // idles high so the emulator side never sees a false start bit
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            one_wire_debug_line_out <= 1'b1;
        end else begin
            one_wire_debug_line_out <= ~debug_claim | pad_in[RESET_PIN];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            debug_active_out <= 1'b0;
        end else begin
            debug_active_out <= debug_claim;
        end
    end

    // ========================================================
    // interrupt sources
    // ========================================================
    // bit n of pin_change_out is source n + PIN_CHANGE_BASE
    assign pin_change_out              = sample_q;
    assign external_interrupt_zero_out = sample_q[INT_ZERO_PIN];

    // ========================================================
    // analog, serial and clock inputs
    // ========================================================
    // digital proxy of the analog path: index 2,1,0 = ch 10,9,8
    assign analog_channel_out = {sample_q[RESET_PIN],
                                 sample_q[INT_ZERO_PIN],
                                 sample_q[OSC_TWO_PIN]};

    assign serial_unit_clock_in_out = sample_q[SER_CLOCK_PIN];
    assign serial_unit_data_in_out  = sample_q[SER_DIN_PIN];

    // sampled copy only; the real oscillator path is analog
    assign external_clock_in_out = osc_one_claim
                                 & sample_q[OSC_ONE_PIN];

endmodule : port_b_alt_function_mux

// >>> dv/portb_mux_asserts.sv
`timescale 1ns/100ps

module portb_mux_checker
    import portb_mux_pkg::*;
(
    input wire logic       ref_clk_in, rst_in,
    input wire port_byte_t pad_in, pad_out, pad_oe_out, pad_pullup_out, port_dir_in,
    input wire port_byte_t dir_read_out, latch_read_out, timer1_control_d_in, pin_change_out,
    input wire logic       reset_disable_fuse_in, debug_enable_fuse_in, lock_bits_programmed_in,
    input wire logic       clock_output_fuse_in, crystal_osc_sel_in, internal_rc_sel_in,
    input wire logic       timer1_a_enable_in, timer1_a_cmp_in, timer1_b_enable_in,
    input wire logic       timer1_b_cmp_in, debug_active_out, reset_request_out,
    input wire logic       external_interrupt_zero_out,
    input wire logic [2:0] analog_channel_out
);
    logic       dbg;
    logic       rclaim;
    logic [4:0] run_q;
    assign dbg    = debug_enable_fuse_in & ~lock_bits_programmed_in;
    assign rclaim = ~reset_disable_fuse_in & ~dbg;

    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    // ==========================================================
    // divided clock must keep toggling; 16 cycles is the slowest half period
    // ==========================================================
    always_ff @(posedge ref_clk_in) begin
        if (rst_in || !clock_output_fuse_in || crystal_osc_sel_in
            || pad_out[5] != $past(pad_out[5])) begin
            run_q <= 5'h00;
        end else begin
            run_q <= run_q + 5'h01;
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    a_debug_claim_flag:
        assert property ($past(!rst_in) |-> debug_active_out == $past(dbg))
        else $error("debug claim flag does not follow fuses");
    a_debug_open_drain:
        assert property ($past(!rst_in && dbg) |-> pad_pullup_out[7] && !(pad_oe_out[7] && pad_out[7]))
        else $error("debug line driven high or pull-up off");
    a_reset_pin_quiet:
        assert property ($past(!rst_in && rclaim) |-> !pad_oe_out[7] && pad_pullup_out[7])
        else $error("reset pin driven as output");
    a_reset_pin_mask:
        assert property ($past(!rst_in && !reset_disable_fuse_in)
                         |-> !dir_read_out[7] && !latch_read_out[7])
        else $error("reset pin readback not zero");
    a_plain_pin_seven:
        assert property ($past(!rst_in && reset_disable_fuse_in && !dbg
                         && !(timer1_b_enable_in && timer1_control_d_in[7]))
                         |-> pad_oe_out[7] == $past(port_dir_in[7])
                         && dir_read_out[7] == $past(port_dir_in[7]))
        else $error("bit 7 not plain io with reset disabled");
    a_timer_a_steer:
        assert property ($past(!rst_in && timer1_a_enable_in && timer1_control_d_in[3]
                         && port_dir_in[6]) |-> pad_oe_out[6] && pad_out[6] == $past(timer1_a_cmp_in))
        else $error("timer a x output not on bit 6");
    a_timer_b_steer:
        assert property ($past(!rst_in && timer1_b_enable_in && timer1_control_d_in[5])
                         |-> pad_oe_out[3] == $past(port_dir_in[3])
                         && (!pad_oe_out[3] || pad_out[3] == $past(timer1_b_cmp_in)))
        else $error("timer b v output not on bit 3");
    a_clock_out_drive:
        assert property ($past(!rst_in && clock_output_fuse_in && !crystal_osc_sel_in)
                         |-> pad_oe_out[5])
        else $error("divided clock not driven on bit 5");
    a_clock_keeps_running:
        assert property (run_q <= 5'h11)
        else $error("divided clock stuck");
    a_crystal_blocks_io:
        assert property ($past(!rst_in && crystal_osc_sel_in) |-> !pad_oe_out[5])
        else $error("crystal pin two driven");
    a_osc_pin_claim:
        assert property ($past(!rst_in && !internal_rc_sel_in)
                         |-> !pad_oe_out[4] && !dir_read_out[4] && !latch_read_out[4])
        else $error("oscillator pin one not claimed");
    a_pin_change_map:
        assert property ($past(!rst_in) |-> pin_change_out == $past(pad_in))
        else $error("pin change sources misrouted");
    a_analog_int_map:
        assert property ($past(!rst_in) |-> analog_channel_out == $past(pad_in[7:5])
                         && external_interrupt_zero_out == $past(pad_in[6]))
        else $error("analog or interrupt source misrouted");

    c_debug_drive: cover property (debug_active_out && pad_oe_out[7]);
    c_reset_req: cover property (reset_request_out);
    c_clock_out: cover property ($rose(pad_out[5]) && pad_oe_out[5]);
endmodule : portb_mux_checker

bind port_b_alt_function_mux portb_mux_checker chk_u (.*);

// >>> dv/board_model.sv
`timescale 1ns/100ps

module board_model
    import portb_mux_pkg::*;
(
    input  wire logic       ref_clk_in,
    input  wire port_byte_t pad_out, pad_oe_out, pad_pullup_out, ext_level, ext_drive,
    output port_byte_t      pad_in
);
    port_byte_t float_q = 8'h5a;
    // an unpulled, undriven pad wanders so a stale value never passes
    always_ff @(posedge ref_clk_in) begin
        float_q <= ~float_q;
    end
    // wired-and debug line: a released line reads ext_level when ext_drive is set, else the pull-up level
    assign pad_in = (pad_oe_out & pad_out) | (~pad_oe_out & ext_drive & ext_level)
                  | (~pad_oe_out & ~ext_drive & (pad_pullup_out | float_q));
endmodule : board_model

// >>> dv/tb_top.sv
`timescale 1ns/100ps

module tb_top;
    import portb_mux_pkg::*;
    logic       ref_clk_in = 1'b0, rst_in = 1'b1;
    port_byte_t pad_in, pad_out, pad_oe_out, pad_pullup_out, ext_level, ext_drive;
    port_byte_t port_dir_in, port_latch_in, timer1_control_d_in;
    port_byte_t dir_read_out, latch_read_out, input_read_out, pin_change_out;
    logic       pullup_disable_in, reset_disable_fuse_in, debug_enable_fuse_in;
    logic       lock_bits_programmed_in, clock_output_fuse_in, crystal_osc_sel_in;
    logic       internal_rc_sel_in, timer1_a_enable_in, timer1_b_enable_in;
    logic       timer1_a_cmp_in, timer1_b_cmp_in, serial_two_wire_in, serial_three_wire_in;
    logic       serial_shiftout_in, serial_clock_hold_in, debug_drive_low_in;
    logic       serial_unit_clock_in_out, serial_unit_data_in_out, one_wire_debug_line_out;
    logic       debug_active_out, reset_request_out, external_interrupt_zero_out;
    logic       external_clock_in_out;
    logic [2:0] analog_channel_out;
    logic [3:0] clock_div_sel_in;
    int         num_errors = 0, samples_checked = 0;

    always #20 ref_clk_in = ~ref_clk_in;

    port_b_alt_function_mux dut_u (.*);
    board_model             board_u (.*);

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_of_test

    function automatic logic dbg();
        return debug_enable_fuse_in & ~lock_bits_programmed_in;
    endfunction : dbg

    function automatic port_byte_t exp_oe();
        port_byte_t e = port_dir_in;
        if (dbg()) e[7] = debug_drive_low_in;
        else if (!reset_disable_fuse_in) e[7] = 1'b0;
        if (crystal_osc_sel_in) e[5] = 1'b0;
        if (!internal_rc_sel_in) e[4] = 1'b0;
        return e;
    endfunction : exp_oe

    // channel a letter k lands on pin 2k, channel b on pin 2k+1
    function automatic port_byte_t exp_val();
        port_byte_t v = port_latch_in;
        for (int k = 0; k < 4; k++) begin
            if (timer1_a_enable_in && timer1_control_d_in[k]) v[2*k] = timer1_a_cmp_in;
            if (timer1_b_enable_in && timer1_control_d_in[k+4]) v[2*k+1] = timer1_b_cmp_in;
        end
        if (dbg()) v[7] = 1'b0;
        return v;
    endfunction : exp_val

    function automatic port_byte_t rd_mask();
        port_byte_t m = 8'hff;
        if (!reset_disable_fuse_in || dbg()) m[7] = 1'b0;
        if (!internal_rc_sel_in) m[4] = 1'b0;
        return m;
    endfunction : rd_mask

    function automatic port_byte_t exp_pu();
        port_byte_t p = port_latch_in & ~port_dir_in & {8{~pullup_disable_in}};
        if (dbg() || !reset_disable_fuse_in) p[7] = 1'b1;
        if (crystal_osc_sel_in) p[5] = 1'b0;
        if (!internal_rc_sel_in) p[4] = 1'b0;
        return p;
    endfunction : exp_pu

    task automatic settle();
        repeat (4) @(posedge ref_clk_in);
        @(negedge ref_clk_in);
    endtask : settle

    task automatic rand_vec();
        logic [31:0] r = $urandom;
        logic [31:0] s = $urandom;
        {port_dir_in, port_latch_in, timer1_control_d_in, ext_level} = r;
        {pullup_disable_in, reset_disable_fuse_in, debug_enable_fuse_in, lock_bits_programmed_in,
         crystal_osc_sel_in, internal_rc_sel_in, timer1_a_enable_in, timer1_b_enable_in,
         timer1_a_cmp_in, timer1_b_cmp_in, debug_drive_low_in} = s[10:0];
        clock_div_sel_in = s[15:12];
        // a plain pin 7 with nobody driving would float
        ext_drive = {s[16] | (reset_disable_fuse_in & ~dbg()), 7'h7f};
        {clock_output_fuse_in, serial_two_wire_in, serial_three_wire_in} = 3'h0;
        {serial_shiftout_in, serial_clock_hold_in} = 2'h0;
    endtask : rand_vec

    task automatic ser(input logic [3:0] mode, input logic [2:0] eoe, input logic [2:0] eout,
                       input logic [2:0] omask);
        {serial_two_wire_in, serial_three_wire_in, serial_shiftout_in, serial_clock_hold_in} = mode;
        settle();
        check({5'h00, pad_oe_out[2:0]}, {5'h00, eoe});
        check({5'h00, pad_out[2:0] & eoe & omask}, {5'h00, eout & eoe & omask});
        check({7'h00, serial_unit_clock_in_out}, {7'h00, pad_in[2]});
        check({7'h00, serial_unit_data_in_out}, {7'h00, pad_in[0]});
    endtask : ser

    task automatic div_period(input logic [3:0] sel);
        int   n = 0;
        logic p;
        clock_div_sel_in = sel;
        clock_output_fuse_in = 1'b1;
        settle();
        check({7'h00, pad_oe_out[5]}, 8'h01);
        for (int t = 0; t < 2; t++) begin
            p = pad_out[5];
            n = 0;
            while (pad_out[5] === p && n < 40) begin
                @(negedge ref_clk_in);
                n++;
            end
        end
        check(8'(n), 8'(sel) + 8'h01);
        if (n >= 40) end_of_test();
    endtask : div_period

    initial begin
        void'($urandom(32'he9593b78));
        rand_vec();
        repeat (2) @(negedge ref_clk_in);
        rst_in = 1'b0;
        check(pad_oe_out, 8'h00);
        check({7'h00, one_wire_debug_line_out}, 8'h01);
        // ======================================================
        // random fuse and timer mixes
        // ======================================================
        repeat (80) begin
            rand_vec();
            settle();
            check(pad_oe_out, exp_oe());
            check(pad_pullup_out, exp_pu());
            check(pad_out & exp_oe(), exp_val() & exp_oe());
            check(dir_read_out, port_dir_in & rd_mask());
            check(latch_read_out, port_latch_in & rd_mask());
            check(input_read_out, pad_in & rd_mask());
            check(pin_change_out, pad_in);
            check({5'h00, analog_channel_out}, {5'h00, pad_in[7:5]});
            check({7'h00, external_interrupt_zero_out}, {7'h00, pad_in[6]});
            check({7'h00, reset_request_out},
                  {7'h00, ~reset_disable_fuse_in & ~dbg() & ~pad_in[7]});
            check({7'h00, external_clock_in_out}, {7'h00, ~internal_rc_sel_in & pad_in[4]});
            check({7'h00, one_wire_debug_line_out}, {7'h00, ~dbg() | pad_in[7]});
        end
        // ======================================================
        // serial defaults on bits 2..0, timers off
        // ======================================================
        timer1_control_d_in = 8'h00;
        port_dir_in = 8'h07;
        port_latch_in = 8'h04;
        ser(4'b1000, 3'b011, 3'b000, 3'b101);
        ser(4'b1011, 3'b110, 3'b000, 3'b101);
        ser(4'b0110, 3'b111, 3'b110, 3'b111);
        ser(4'b0100, 3'b111, 3'b100, 3'b111);
        // ======================================================
        // divided clock on bit 5 overrides direction
        // ======================================================
        crystal_osc_sel_in = 1'b0;
        port_dir_in = 8'h00;
        div_period(4'h0);
        div_period(4'h5);
        div_period(4'hf);
        end_of_test();
    end
endmodule : tb_top
